// [rtl/fml_map.svh]
`ifndef FML_MAP_SVH
`define FML_MAP_SVH

// Register offsets on the plain register port
`define FML_REG_CMD     8'h00
`define FML_REG_ARG     8'h04
`define FML_REG_STATUS  8'h08
`define FML_REG_OPT     8'h0c
`define FML_REG_DESC    8'h10
`define FML_REG_UID0    8'h14
`define FML_REG_CAL     8'h24

// Status register bit positions
`define FML_ST_BUSY     0
`define FML_ST_DONE     1
`define FML_ST_ABORT    2
`define FML_ST_ERR      3
`define FML_ST_SECURE   4
`define FML_ST_FAST     5

// Option bit positions and power-up value
`define FML_OPT_SECURE  0
`define FML_OPT_BOOT    1
`define FML_OPT_SWAP    2
`define FML_OPT_RST     3'h0

// Memory map
`define FML_ROM_BASE    32'h0080_0000
`define FML_FLASH_BASE  32'h0040_0000
`define FML_BANK_SIZE   32'h0010_0000
`define FML_SRAM_BASE   32'h2000_0000
`define FML_BB_BASE     32'h2200_0000
`define FML_BB_LAST     32'h23ff_ffff

// Flash geometry
`define FML_PAGE_BYTES  32'h0000_0200
`define FML_SECT_BYTES  32'h0001_0000
`define FML_SMALL_BYTES 32'h0000_2000
`define FML_LOCK_BYTES  32'h0000_2000
`define FML_BLOCK_BYTES 32'h0000_1000
`define FML_BANKS       32'h0000_0002

// Wipe pin timing
`define FML_CLK_KHZ     10000
`define FML_WIPE_IGN_MS 100
`define FML_WIPE_MS     220
`define FML_WIPE_CYC    (`FML_WIPE_MS * `FML_CLK_KHZ + 1)

`endif

// [rtl/fml_pkg.sv]
package fml_pkg;

    // Decoded bus target
    typedef enum logic [2:0] {
        TGT_NONE, TGT_ROM, TGT_FLASH0, TGT_FLASH1, TGT_SRAM, TGT_BITBAND
    } fml_target_t;

    // Commands, shared by software and the fast programming port
    typedef enum logic [3:0] {
        CMD_NOP, CMD_READ_FLASH, CMD_WRITE_PAGE, CMD_ERASE_PAGE,
        CMD_PAGE_WIPE_THEN_WRITE, CMD_PAGE_WIPE_WRITE_LOCK, CMD_ERASE_4K,
        CMD_ERASE_SECTOR, CMD_ERASE_CHIP, CMD_SET_LOCK, CMD_CLR_LOCK,
        CMD_SET_OPT, CMD_CLR_OPT, CMD_READ_SIG, CMD_WRITE_SIG, CMD_ERASE_SIG
    } fml_cmd_t;

    // Command engine states
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WIPE} fml_state_t;

endpackage : fml_pkg

// [rtl/fml_wipe_filter.sv]
`timescale 1ns/100ps
`include "fml_map.svh"
// Fires one pulse once the wipe pin has been high for TRIG_CYC cycles
module fml_wipe_filter #(
    parameter int TRIG_CYC = `FML_WIPE_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      fire
);
    logic [22:0] cnt_r;   // Cycles the pin has stayed high
    logic [22:0] cnt_nxt;
    logic        fire_r;  // Wipe trigger pulse
    logic        fire_nxt;

    // Short highs fall back to zero, so glitches never fire
    always_comb begin
        cnt_nxt  = cnt_r;
        fire_nxt = 1'b0;
        if (!pin) begin
            cnt_nxt = '0;
        end else if (cnt_r < 23'(TRIG_CYC)) begin
            cnt_nxt  = cnt_r + 23'h1;
            fire_nxt = (cnt_nxt == 23'(TRIG_CYC));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            fire_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign fire = fire_r;
endmodule : fml_wipe_filter

// [rtl/fml_lock_bank.sv]
`timescale 1ns/100ps
// Per-region lock bits of both banks
module fml_lock_bank #(
    parameter int NREG = 256
) (
    input  wire logic       clk,
    input  wire logic       rst,
    // Updates
    input  wire logic       set_en,
    input  wire logic       clr_en,
    input  wire logic       clr_all,
    input  wire logic [7:0] idx,
    // Queries
    input  wire logic       qry_sector,
    output logic            locked,
    output logic            any_locked
);
    logic [NREG-1:0] bits_r;   // One bit per 8 KB region
    logic [NREG-1:0] bits_nxt;
    logic [7:0]      base;     // First region of the 64 KB sector

    // Clear-all wins over single updates
    always_comb begin
        bits_nxt = bits_r;
        if (clr_all) begin
            bits_nxt = '0;
        end else if (set_en) begin
            bits_nxt[idx] = 1'b1;
        end else if (clr_en) begin
            bits_nxt[idx] = 1'b0;
        end
    end

    // Sector queries cover every region the erase touches
    always_comb begin
        base   = {idx[7:3], 3'h0};
        locked = bits_r[idx];
        if (qry_sector && !(idx[6:3] == 4'h0 && idx[2:1] == 2'h0)) begin
            if (idx[6:3] == 4'h0) begin
                locked = |bits_r[base+8'h2 +: 6];
            end else begin
                locked = |bits_r[base +: 8];
            end
        end
        any_locked = |bits_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bits_r <= '0;
        end else begin
            bits_r <= bits_nxt;
        end
    end
endmodule : fml_lock_bank

// [rtl/fml_top.sv]
`timescale 1ns/100ps
`include "fml_map.svh"
module fml_top #(
    parameter int          WIPE_CYC = `FML_WIPE_CYC,
    parameter logic [127:0] UID     = 128'h0123_4567_89ab_cdef_0011_2233_4455_6677, // Arbitrary
    parameter logic [31:0] CAL      = 32'h0000_5a5a // Arbitrary
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // Register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // System bus decode
    input  wire logic        BUS_VALID,
    input  wire logic [31:0] BUS_ADDR,
    output logic             DEC_VALID,
    output logic      [2:0]  DEC_TARGET,
    output logic      [19:0] DEC_OFFSET,
    output logic      [2:0]  DEC_BIT,
    // Flash array operations
    output logic             ARR_REQ,
    output logic      [3:0]  ARR_OP,
    output logic      [20:0] ARR_ADDR,
    input  wire logic        ARR_DONE,
    // Pins
    input  wire logic        WIPE_PIN,
    input  wire logic        TEST_MODE_PIN,
    input  wire logic        PORT_A_LINE_ZERO,
    input  wire logic        PORT_A_LINE_ONE,
    // Fast programming port
    input  wire logic        FP_CMD_VALID,
    input  wire logic [3:0]  FP_CMD,
    input  wire logic [20:0] FP_ADDR,
    output logic             FP_ACCEPT,
    output logic             FP_REFUSED,
    // Debug probe gate
    input  wire logic        DBG_REQ,
    output logic             DBG_GRANT,
    output logic             DBG_DENY,
    // Status outputs
    output logic             LOCK_ABORT_IRQ,
    output logic             SECURE,
    output logic             BOOT_FROM_FLASH,
    output logic             BANK_SWAP,
    output logic             FAST_PROG_MODE
);
    fml_pkg::fml_state_t  state_r, state_nxt;   // Command engine state
    fml_pkg::fml_cmd_t    cmd_r, cmd_nxt;       // Command in flight
    logic [20:0]          arg_r, arg_nxt;       // Command address / index
    logic [2:0]           opt_r = `FML_OPT_RST, opt_nxt; // Nonvolatile option bits
    logic                 done_r, done_nxt;     // Sticky: command done
    logic                 abort_r, abort_nxt;   // Sticky: lock abort
    logic                 err_r, err_nxt;       // Sticky: bad command
    logic                 req_r, req_nxt;       // Array request pulse
    logic                 fpa_r, fpa_nxt;       // Fast port accept pulse
    logic                 fpr_r, fpr_nxt;       // Fast port refuse pulse
    logic                 sampled_r;            // Remap already sampled
    logic                 boot_r, swap_r;       // Remap held until reset
    logic                 fast_r;               // Fast programming mode
    logic                 grant_r, deny_r;      // Debug gate answers
    logic [31:0]          rdata_r, rdata_nxt;   // Read data
    logic                 dv_r;                 // Decode valid
    fml_pkg::fml_target_t tgt_r, tgt_nxt;       // Decoded target
    logic [19:0]          off_r, off_nxt;       // Decoded offset
    logic [2:0]           bit_r, bit_nxt;       // Bit-band bit number
    // Command sources and lock bank hooks
    logic                 wipe;
    logic                 sw_go, fp_go, go;
    fml_pkg::fml_cmd_t    go_cmd;
    logic [20:0]          go_arg;
    logic                 lk_set, lk_clr, lk_all, lk_sector;
    logic [7:0]           lk_idx;
    logic                 lk_hit, lk_any;

    // True when the bank offset lies in an 8 KB subsector
    function automatic logic in_small(input logic [19:0] off);
        return off < 20'(`FML_SMALL_BYTES * 2);
    endfunction : in_small

    // Which physical bank answers at a given flash slot
    function automatic fml_pkg::fml_target_t bank_at(input logic slot, input logic swp);
        return (slot ^ swp) ? fml_pkg::TGT_FLASH1 : fml_pkg::TGT_FLASH0;
    endfunction : bank_at

    fml_wipe_filter #(
        .TRIG_CYC (WIPE_CYC)
    ) u_wipe (
        .clk  (SYS_CLK),
        .rst  (RESET),
        .pin  (WIPE_PIN),
        .fire (wipe)
    );

    fml_lock_bank u_lock (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .set_en     (lk_set),
        .clr_en     (lk_clr),
        .clr_all    (lk_all),
        .idx        (lk_idx),
        .qry_sector (lk_sector),
        .locked     (lk_hit),
        .any_locked (lk_any)
    );

    // Software wins the engine; a clashing fast port command is refused
    always_comb begin
        sw_go  = REG_WR && REG_ADDR == `FML_REG_CMD;
        fp_go  = FP_CMD_VALID && fast_r && !opt_r[`FML_OPT_SECURE]
                 && state_r == fml_pkg::ST_IDLE && !sw_go && !wipe;
        go     = (sw_go || fp_go) && state_r == fml_pkg::ST_IDLE && !wipe;
        go_cmd = sw_go ? fml_pkg::fml_cmd_t'(REG_WDATA[3:0])
                       : fml_pkg::fml_cmd_t'(FP_CMD);
        go_arg = sw_go ? arg_r : FP_ADDR;
        lk_idx    = go ? {go_arg[20], go_arg[19:13]} : {arg_r[20], arg_r[19:13]};
        lk_sector = go_cmd == fml_pkg::CMD_ERASE_SECTOR;
    end

    // Command engine
    always_comb begin
        state_nxt = state_r;
        cmd_nxt   = cmd_r;
        arg_nxt   = arg_r;
        opt_nxt   = opt_r;
        done_nxt  = done_r;
        abort_nxt = abort_r;
        err_nxt   = err_r;
        req_nxt   = 1'b0;
        fpa_nxt   = fp_go;
        fpr_nxt   = FP_CMD_VALID && !fp_go;
        lk_set    = 1'b0;
        lk_clr    = 1'b0;
        lk_all    = 1'b0;
        // Reading status clears sticky flags; a new event set below wins
        if (REG_RD && REG_ADDR == `FML_REG_STATUS) begin
            done_nxt  = 1'b0;
            abort_nxt = 1'b0;
            err_nxt   = 1'b0;
        end
        if (REG_WR && REG_ADDR == `FML_REG_ARG) begin
            arg_nxt = REG_WDATA[20:0];
        end
        case (state_r)
            fml_pkg::ST_IDLE: begin
                if (wipe) begin
                    lk_all    = 1'b1;
                    opt_nxt[`FML_OPT_BOOT] = 1'b0;
                    opt_nxt[`FML_OPT_SWAP] = 1'b0;
                    cmd_nxt   = fml_pkg::CMD_ERASE_CHIP; // Signature excluded
                    req_nxt   = 1'b1;
                    state_nxt = fml_pkg::ST_WIPE;
                end else if (go) begin
                    cmd_nxt = go_cmd;
                    arg_nxt = go_arg;
                    case (go_cmd)
                        fml_pkg::CMD_NOP: begin
                            done_nxt = 1'b1;
                        end
                        fml_pkg::CMD_SET_LOCK: begin
                            lk_set   = 1'b1;
                            done_nxt = 1'b1;
                        end
                        fml_pkg::CMD_CLR_LOCK: begin
                            lk_clr   = 1'b1;
                            done_nxt = 1'b1;
                        end
                        fml_pkg::CMD_SET_OPT: begin
                            if (go_arg[1:0] == 2'h3) begin
                                err_nxt = 1'b1;
                            end else begin
                                opt_nxt[go_arg[1:0]] = 1'b1;
                                done_nxt = 1'b1;
                            end
                        end
                        fml_pkg::CMD_CLR_OPT: begin
                            // Security bit can only be cleared by the wipe
                            if (go_arg[1:0] == 2'h3 || go_arg[1:0] == 2'h0) begin
                                err_nxt = 1'b1;
                            end else begin
                                opt_nxt[go_arg[1:0]] = 1'b0;
                                done_nxt = 1'b1;
                            end
                        end
                        fml_pkg::CMD_READ_FLASH, fml_pkg::CMD_READ_SIG,
                        fml_pkg::CMD_WRITE_SIG, fml_pkg::CMD_ERASE_SIG: begin
                            // Signature page reached only by its own modes
                            req_nxt   = 1'b1;
                            state_nxt = fml_pkg::ST_EXEC;
                        end
                        fml_pkg::CMD_ERASE_CHIP: begin
                            if (lk_any) begin
                                abort_nxt = 1'b1;
                            end else begin
                                req_nxt   = 1'b1; // Array fills with ones
                                state_nxt = fml_pkg::ST_EXEC;
                            end
                        end
                        default: begin
                            // Program and region erases
                            if (lk_hit) begin
                                abort_nxt = 1'b1;
                            end else if ((go_cmd == fml_pkg::CMD_ERASE_PAGE
                                    || go_cmd == fml_pkg::CMD_PAGE_WIPE_THEN_WRITE
                                    || go_cmd == fml_pkg::CMD_PAGE_WIPE_WRITE_LOCK)
                                    && !in_small(go_arg[19:0])) begin
                                err_nxt = 1'b1;
                            end else begin
                                req_nxt   = 1'b1;
                                state_nxt = fml_pkg::ST_EXEC;
                            end
                        end
                    endcase
                end else if (sw_go) begin
                    err_nxt = 1'b1;
                end
            end
            fml_pkg::ST_EXEC: begin
                if (sw_go) begin
                    err_nxt = 1'b1;
                end
                if (ARR_DONE) begin
                    done_nxt  = 1'b1;
                    lk_set    = cmd_r == fml_pkg::CMD_PAGE_WIPE_WRITE_LOCK;
                    state_nxt = fml_pkg::ST_IDLE;
                end
            end
            fml_pkg::ST_WIPE: begin
                if (sw_go) begin
                    err_nxt = 1'b1;
                end
                if (ARR_DONE) begin
                    opt_nxt[`FML_OPT_SECURE] = 1'b0;
                    done_nxt  = 1'b1;
                    state_nxt = fml_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = fml_pkg::ST_IDLE;
            end
        endcase
    end

    // Register reads; identifier and calibration are constants
    always_comb begin
        rdata_nxt = 32'h0;
        if (REG_RD) begin
            case (REG_ADDR)
                `FML_REG_ARG:    rdata_nxt = {11'h0, arg_r};
                `FML_REG_STATUS: rdata_nxt = {26'h0, fast_r,
                                  opt_r[`FML_OPT_SECURE], err_r, abort_r, done_r,
                                  state_r != fml_pkg::ST_IDLE};
                `FML_REG_OPT:    rdata_nxt = {29'h0, opt_r};
                `FML_REG_DESC: begin
                    case (arg_r[2:0])
                        3'h0:    rdata_nxt = `FML_BANKS;
                        3'h1:    rdata_nxt = `FML_BANK_SIZE;
                        3'h2:    rdata_nxt = `FML_SECT_BYTES;
                        3'h3:    rdata_nxt = `FML_SMALL_BYTES;
                        3'h4:    rdata_nxt = `FML_PAGE_BYTES;
                        3'h5:    rdata_nxt = `FML_LOCK_BYTES;
                        3'h6:    rdata_nxt = `FML_BLOCK_BYTES;
                        default: rdata_nxt = 32'h0;
                    endcase
                end
                8'h14:       rdata_nxt = UID[31:0];
                8'h18:       rdata_nxt = UID[63:32];
                8'h1c:       rdata_nxt = UID[95:64];
                8'h20:       rdata_nxt = UID[127:96];
                `FML_REG_CAL: rdata_nxt = CAL;
                default:     rdata_nxt = 32'h0;
            endcase
        end
    end

    // Address decode against the remap held since reset release
    always_comb begin
        tgt_nxt = fml_pkg::TGT_NONE;
        off_nxt = BUS_ADDR[19:0];
        bit_nxt = 3'h0;
        if (BUS_ADDR < `FML_FLASH_BASE) begin
            // Fetch starts at zero: ROM or first flash slot
            tgt_nxt = boot_r ? bank_at(1'b0, swap_r) : fml_pkg::TGT_ROM;
        end else if (BUS_ADDR < `FML_FLASH_BASE + 2 * `FML_BANK_SIZE) begin
            tgt_nxt = bank_at(BUS_ADDR[20], swap_r);
        end else if (BUS_ADDR[31:20] == `FML_ROM_BASE >> 20) begin
            tgt_nxt = fml_pkg::TGT_ROM;
        end else if (BUS_ADDR[31:20] == `FML_SRAM_BASE >> 20) begin
            tgt_nxt = fml_pkg::TGT_SRAM;
        end else if (BUS_ADDR >= `FML_BB_BASE && BUS_ADDR <= `FML_BB_LAST) begin
            // Each alias word maps to one SRAM bit
            tgt_nxt = fml_pkg::TGT_BITBAND;
            off_nxt = BUS_ADDR[24:5];
            bit_nxt = BUS_ADDR[4:2];
        end
    end

    // Command engine, sticky flag, pulse and read data registers
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_r <= fml_pkg::ST_IDLE;
            cmd_r   <= fml_pkg::CMD_NOP;
            arg_r   <= '0;
            done_r  <= 1'b0;
            abort_r <= 1'b0;
            err_r   <= 1'b0;
            req_r   <= 1'b0;
            fpa_r   <= 1'b0;
            fpr_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            cmd_r   <= cmd_nxt;
            arg_r   <= arg_nxt;
            done_r  <= done_nxt;
            abort_r <= abort_nxt;
            err_r   <= err_nxt;
            req_r   <= req_nxt;
            fpa_r   <= fpa_nxt;
            fpr_r   <= fpr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Option bits ride through RESET, else a remap could never take effect
    always_ff @(posedge SYS_CLK) begin
        opt_r <= opt_nxt;
    end

    // Remap, mode pins, debug gate and decode registers
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sampled_r <= 1'b0;
            boot_r    <= 1'b0;
            swap_r    <= 1'b0;
            fast_r    <= 1'b0;
            grant_r   <= 1'b0;
            deny_r    <= 1'b0;
            dv_r      <= 1'b0;
            tgt_r     <= fml_pkg::TGT_NONE;
            off_r     <= '0;
            bit_r     <= '0;
        end else begin
            sampled_r <= 1'b1;
            if (!sampled_r) begin
                boot_r <= opt_r[`FML_OPT_BOOT];
                swap_r <= opt_r[`FML_OPT_SWAP];
            end
            fast_r  <= !TEST_MODE_PIN && !PORT_A_LINE_ZERO && !PORT_A_LINE_ONE;
            grant_r <= DBG_REQ && !opt_r[`FML_OPT_SECURE];
            deny_r  <= DBG_REQ && opt_r[`FML_OPT_SECURE];
            dv_r    <= BUS_VALID;
            tgt_r   <= tgt_nxt;
            off_r   <= off_nxt;
            bit_r   <= bit_nxt;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA       = rdata_r;
    assign DEC_VALID       = dv_r;
    assign DEC_TARGET      = tgt_r;
    assign DEC_OFFSET      = off_r;
    assign DEC_BIT         = bit_r;
    assign ARR_REQ         = req_r;
    assign ARR_OP          = cmd_r;
    assign ARR_ADDR        = arg_r;
    assign FP_ACCEPT       = fpa_r;
    assign FP_REFUSED      = fpr_r;
    assign DBG_GRANT       = grant_r;
    assign DBG_DENY        = deny_r;
    assign LOCK_ABORT_IRQ  = abort_r;
    assign SECURE          = opt_r[`FML_OPT_SECURE];
    assign BOOT_FROM_FLASH = boot_r;
    assign BANK_SWAP       = swap_r;
    assign FAST_PROG_MODE  = fast_r;
endmodule : fml_top

// [bench/fml_array_model.sv]
`timescale 1ns/100ps
// Flash array stand-in: each start gets one done pulse, fast or slow
module fml_array_model (
    input wire logic clk,  // System clock
    input wire logic rst,  // Reset
    input wire logic slow, // Stretch the answer
    input wire logic req,  // Operation start
    output logic     done  // Operation finished
);
    logic [3:0] cnt_r, cnt_nxt; // Cycles left
    logic       done_nxt;       // Next done
    // Count down; a slow answer tests that the engine really waits
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'h0;
        if (req) cnt_nxt = slow ? 4'h6 : 4'h1;
        else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
            done_nxt = (cnt_r == 4'h1);
        end
    end
    // Registers only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {cnt_r, done} <= 5'h0;
        else {cnt_r, done} <= {cnt_nxt, done_nxt};
    end
endmodule : fml_array_model

// [bench/fml_top_checker.sv]
`timescale 1ns/100ps
// Watches decode, gating and abort at the top ports
module fml_top_checker (
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        BUS_VALID,
    input wire logic [31:0] BUS_ADDR,
    input wire logic [2:0]  DEC_TARGET,
    input wire logic [2:0]  DEC_BIT,
    input wire logic        ARR_REQ,
    input wire logic        TEST_MODE_PIN,
    input wire logic        PORT_A_LINE_ZERO,
    input wire logic        PORT_A_LINE_ONE,
    input wire logic        FP_CMD_VALID,
    input wire logic        FP_ACCEPT,
    input wire logic        FP_REFUSED,
    input wire logic        DBG_REQ,
    input wire logic        DBG_GRANT,
    input wire logic        DBG_DENY,
    input wire logic        LOCK_ABORT_IRQ,
    input wire logic        SECURE,
    input wire logic        BOOT_FROM_FLASH,
    input wire logic        BANK_SWAP,
    input wire logic        FAST_PROG_MODE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire pins_low = !(TEST_MODE_PIN | PORT_A_LINE_ZERO | PORT_A_LINE_ONE); // Entry pins
    AST_ROM: assert property (BUS_VALID && BUS_ADDR[31:20] == 12'h008 |=> DEC_TARGET == 3'h1)
        else $error("rom decode");
    AST_BITBAND: assert property (BUS_VALID && BUS_ADDR[31:25] == 7'h11 |=>
        DEC_TARGET == 3'h5 && DEC_BIT == $past(BUS_ADDR[4:2])) else $error("alias decode");
    AST_BOOT: assert property (BUS_VALID && BUS_ADDR[31:22] == 10'h0 |=>
        DEC_TARGET == (BOOT_FROM_FLASH ? 3'h2 + BANK_SWAP : 3'h1)) else $error("boot decode");
    AST_BANK: assert property (BUS_VALID && BUS_ADDR[31:20] == 12'h005 |=>
        DEC_TARGET == 3'h3 - BANK_SWAP) else $error("bank order");
    AST_DBG: assert property (DBG_REQ |=> DBG_DENY == $past(SECURE) && DBG_GRANT != $past(SECURE))
        else $error("debug gate");
    AST_FPREF: assert property (FP_CMD_VALID && SECURE |=> FP_REFUSED && !FP_ACCEPT)
        else $error("fast port open");
    AST_FPMODE: assert property (!$past(RESET) |-> FAST_PROG_MODE == $past(pins_low))
        else $error("fast mode entry");
    AST_ABORT: assert property ($rose(LOCK_ABORT_IRQ) |-> !ARR_REQ && !$past(ARR_REQ))
        else $error("locked op started");
    cover property (FP_ACCEPT);
    cover property ($rose(LOCK_ABORT_IRQ));
    cover property (DBG_DENY);
endmodule : fml_top_checker
bind fml_top fml_top_checker fml_top_checker_i (.*);

// [bench/fml_top_tb.sv]
`timescale 1ns/100ps
module fml_top_tb;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, bv = 0, wp = 0, tp = 1, dq = 0, fv = 0, slow = 0;
    logic [7:0]  ra = 0;                                     // Register offset
    logic [31:0] wd = 0, rdat, rv, ba = 0, seed = 32'h347a246c; // Bus values, xorshift state
    logic        areq, adone, fa, fr, dg, dd, irq, sec, bff, bsw;
    logic [2:0]  tgt;                                        // Decoded target
    logic [1:0]  rm = 0;                                     // Expected boot, swap
    logic [3:0]  aop, lop = 0;                               // Last array op seen
    int          n_fail = 0, n_tests = 0, cyc = 0, nreq = 0;
    logic [31:0] dt [7] = '{32'h2, 32'h10_0000, 32'h1_0000, 32'h2000, 32'h200, 32'h2000, 32'h1000};
    logic [31:0] bases [8] = '{32'h0, 32'h40_0000, 32'h50_0000, 32'h80_0000, 32'h2000_0000,
                               32'h2200_0000, 32'h23f0_0000, 32'h60_0000};
    fml_top #(.WIPE_CYC(20)) fml_top_i (.SYS_CLK(clk), .RESET(rst), .REG_ADDR(ra), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .BUS_VALID(bv), .BUS_ADDR(ba), .DEC_VALID(),
        .DEC_TARGET(tgt), .DEC_OFFSET(), .DEC_BIT(), .ARR_REQ(areq), .ARR_OP(aop), .ARR_ADDR(),
        .ARR_DONE(adone), .WIPE_PIN(wp), .TEST_MODE_PIN(tp), .PORT_A_LINE_ZERO(tp),
        .PORT_A_LINE_ONE(tp), .FP_CMD_VALID(fv), .FP_CMD(wd[3:0]), .FP_ADDR(wd[20:0]),
        .FP_REFUSED(fr), .DBG_REQ(dq), .DBG_GRANT(dg), .DBG_DENY(dd), .LOCK_ABORT_IRQ(irq),
        .FP_ACCEPT(fa), .SECURE(sec), .BOOT_FROM_FLASH(bff), .BANK_SWAP(bsw), .FAST_PROG_MODE());
    fml_array_model fml_array_model_i (.clk(clk), .rst(rst), .slow(slow), .req(areq), .done(adone));
    initial forever #50 clk = ~clk;
    // Array start watcher and hang guard
    always @(posedge clk) begin
        cyc++;
        if (areq) begin nreq++; lop = aop; end
        if (cyc == 20000) begin n_fail++; results(); end
    end
    function logic [31:0] xs();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; return seed;
    endfunction : xs
    // Expected target under the remap rm (boot, swap) held since reset
    function logic [2:0] ex(logic [31:0] a);
        if (a[31:22] == 10'h0 && !rm[1] || a[31:20] == 12'h008) return 3'h1;
        if (a[31:22] == 10'h0 || a[31:20] == 12'h004) return 3'h2 + rm[0];
        if (a[31:20] == 12'h005) return 3'h3 - rm[0];
        if (a[31:20] == 12'h200) return 3'h4;
        return (a[31:25] == 7'h11) ? 3'h5 : 3'h0;
    endfunction : ex
    task chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin n_fail++; $display("Error %0t: got %h want %h", $time, g, e); end
    endtask : chk
    task wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); ra <= a; wd <= d; wr <= 1; @(posedge clk); wr <= 0;
    endtask : wrr
    task rdr(input logic [7:0] a);
        @(posedge clk); ra <= a; rd <= 1; @(posedge clk); rd <= 0; @(negedge clk); rv = rdat;
    endtask : rdr
    task cmd(input logic [31:0] a, input logic [3:0] c);
        slow <= ^xs(); wrr(8'h04, a); wrr(8'h00, {28'h0, c}); repeat (12) @(posedge clk);
    endtask : cmd
    task dec(input logic [31:0] a);
        @(posedge clk); bv <= 1; ba <= a; @(posedge clk); bv <= 0; @(negedge clk);
        chk(tgt, ex(a));
    endtask : dec
    task fpd(input logic [3:0] e);
        @(posedge clk); fv <= 1; dq <= 1; @(posedge clk); fv <= 0; dq <= 0; @(negedge clk);
        chk({fa, fr, dg, dd}, e);
    endtask : fpd
    task results();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        dec(32'h003f_ffff); dec(32'h2400_0000); dec(32'h21ff_ffff);
        repeat (30) dec(bases[xs() % 8] | (seed >> 12));
        for (int i = 0; i < 7; i++) begin wrr(8'h04, i); rdr(8'h10); chk(rv, dt[i]); end
        rdr(8'h24); chk(rv, 32'h5a5a); wrr(8'h24, 32'h0); rdr(8'h24); chk(rv, 32'h5a5a);
        cmd(32'h2000, 4'h9); cmd(32'h2000, 4'h3); chk(irq, 1);
        rdr(8'h08); chk(rv[2], 1); chk(nreq, 0);
        cmd(32'h2000, 4'ha); cmd(32'h2000, 4'h3); chk(lop, 4'h3);
        cmd(32'h1_0000, 4'h3); rdr(8'h08); chk(rv[3], 1);
        cmd(32'h2, 4'hb); cmd(32'h1, 4'hb); rdr(8'h0c); chk(rv[2:0], 3'h6);
        chk({bff, bsw}, 2'h0);
        @(posedge clk) rst <= 1; @(posedge clk) rst <= 0; rm = 2'h3;
        repeat (6) dec(bases[xs() % 3] | (seed >> 12)); chk({bff, bsw}, 2'h3);
        @(posedge clk) tp <= 0; fpd(4'ha);
        cmd(32'h0, 4'hb); chk(sec, 1); fpd(4'h5);
        cmd(32'h2000, 4'h9); nreq = 0;
        wp <= 1; repeat (10) @(posedge clk); wp <= 0; repeat (12) @(posedge clk);
        chk(nreq, 0);
        wp <= 1; repeat (30) @(posedge clk); wp <= 0; repeat (12) @(posedge clk);
        chk(lop, 4'h8); chk(sec, 0); rdr(8'h0c); chk(rv[2:0], 3'h0);
        cmd(32'h2000, 4'h3); chk(lop, 4'h3);
        chk({bff, bsw}, 2'h3); rdr(8'h24); chk(rv, 32'h5a5a);
        results();
    end
endmodule : fml_top_tb
